// ### dhis_map.vh
`ifndef DHIS_MAP_VH
`define DHIS_MAP_VH
`define DHIS_ADDR_FIXED      5'h07
`define DHIS_ADDR_FIXED_MSB  6
`define DHIS_ADDR_FIXED_LSB  2
`define DHIS_RW_BIT          0
`define DHIS_RW_WRITE        1'h0
`define DHIS_RW_READ         1'h1
`define DHIS_CLK_HZ          10000000
`define DHIS_MAX_SCL_HZ      100000
`define DHIS_SCL_PERIOD_CYC  (`DHIS_CLK_HZ / `DHIS_MAX_SCL_HZ)
`define DHIS_BITS_PER_BYTE   4'h8
`endif

// ### dhis_i2c_slave.v
`timescale 1ns/1ns
`include "dhis_map.vh"
// Function
// RULE_01 - Strap low selects I2C slave mode using SDA data and SCL clock.
// RULE_02 - Mode strap captured during reset; high selects the 4-wire mode instead.
// RULE_03 - Address is fixed 0,0,1,1,1 then high strap, then low strap.
// RULE_04 - Strap low gives address bit 0, strap high gives 1.
// RULE_05 - Host opens each transfer with START, then the address byte.
// RULE_06 - Address byte carries seven address bits first, direction bit last.
// RULE_07 - On address match, device pulls SDA low in the ninth clock.
// RULE_08 - Direction 0 means host writes; 1 means host reads.
// RULE_09 - Direction holds for the whole transfer until STOP.
// RULE_10 - Exactly one data byte follows the address byte.
// RULE_11 - Standard mode only, SCL at most 100 kbps.
// RULE_12 - On mismatch, SDA stays released until the next START.
module dhis_i2c_slave (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       mode_select_strap_i,
  input  wire       addr_strap_low_i,
  input  wire       addr_strap_high_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  output reg        i2c_mode_o,
  output reg [7:0]  rx_data_o,
  output reg        rx_valid_o,
  input  wire [7:0] tx_data_i,
  output reg        tx_taken_o,
  output reg        busy_o
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_AACK  = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_WACK  = 3'h4;
  localparam ST_RDATA = 3'h5;
  localparam ST_RACK  = 3'h6;
  localparam ST_WAIT  = 3'h7;

  reg [2:0] scl_sync_reg;
  reg [2:0] sda_sync_reg;
  reg       scl_reg;
  reg       sda_reg;
  reg [6:0] own_addr_reg;
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg       dir_reg;

  wire scl_rise = ~scl_reg & scl_sync_reg[2] & scl_sync_reg[1];
  wire scl_fall = scl_reg & ~scl_sync_reg[2] & ~scl_sync_reg[1];
  wire sda_new_ok = (sda_sync_reg[2] == sda_sync_reg[1]);
  wire sda_new = sda_sync_reg[2];
  wire start_det = scl_reg & sda_new_ok & sda_reg & ~sda_new;
  wire stop_det  = scl_reg & sda_new_ok & ~sda_reg & sda_new;

  // Byte boundary shared by address, write and read paths
  function byte_done;
    input [3:0] cnt;
    begin
      byte_done = (cnt == `DHIS_BITS_PER_BYTE);
    end
  endfunction

  // Serial receive shift, MSB first
  function [7:0] shift_in;
    input [7:0] cur;
    input       bit_in;
    begin
      shift_in = {cur[6:0], bit_in};
    end
  endfunction

  // Open drain: a zero is sent by pulling low, a one by releasing
  function pull_for;
    input bit_val;
    begin
      pull_for = ~bit_val;
    end
  endfunction

  // Pins cross from the host domain; change counts when stages 2 and 3 agree
  always @(posedge clk_i) begin
    scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
    sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
    if (rst_i) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      if (scl_sync_reg[2] == scl_sync_reg[1])
        scl_reg <= scl_sync_reg[2];
      if (sda_new_ok)
        sda_reg <= sda_new;
    end
  end

  // RULE_02 strap capture in reset
  // Straps are sampled while reset is held, so a live pin change later is ignored
  always @(posedge clk_i) begin
    if (rst_i) begin
      i2c_mode_o   <= ~mode_select_strap_i;
      // RULE_03 address from straps
      // RULE_04 strap level to bit
      own_addr_reg <= {`DHIS_ADDR_FIXED, addr_strap_high_i, addr_strap_low_i};
    end
  end

  // RULE_11 standard mode sampling: 10 MHz gives about 100 samples per SCL period
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      dir_reg     <= `DHIS_RW_WRITE;
      sda_o       <= 1'b0;
      sda_oe_o    <= 1'b0;
      rx_data_o   <= 8'h00;
      rx_valid_o  <= 1'b0;
      tx_taken_o  <= 1'b0;
      busy_o      <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      tx_taken_o <= 1'b0;
      // RULE_01 idle unless I2C mode
      if (!i2c_mode_o) begin
        state_reg <= ST_IDLE;
        sda_oe_o  <= 1'b0;
        busy_o    <= 1'b0;
      // RULE_05 START opens transfer
      end else if (start_det) begin
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_o    <= 1'b0;
        busy_o      <= 1'b1;
      // RULE_09 STOP ends transfer
      end else if (stop_det) begin
        state_reg <= ST_IDLE;
        sda_oe_o  <= 1'b0;
        busy_o    <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_oe_o <= 1'b0;
          end
          // RULE_06 address bits MSB first, direction last
          ST_ADDR: begin
            if (scl_rise) begin
              shift_reg   <= shift_in(shift_reg, sda_reg);
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && byte_done(bit_cnt_reg)) begin
              bit_cnt_reg <= 4'h0;
              if (shift_reg[7:1] == own_addr_reg) begin
                // RULE_07 acknowledge in ninth clock
                sda_oe_o  <= 1'b1;
                // RULE_08 direction decode
                dir_reg   <= shift_reg[`DHIS_RW_BIT];
                state_reg <= ST_AACK;
              end else begin
                // RULE_12 mismatch keeps SDA released
                state_reg <= ST_WAIT;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (dir_reg == `DHIS_RW_READ) begin
                sda_oe_o   <= pull_for(tx_data_i[7]);
                shift_reg  <= {tx_data_i[6:0], 1'b0};
                tx_taken_o <= 1'b1;
                bit_cnt_reg <= 4'h1;
                state_reg  <= ST_RDATA;
              end else begin
                sda_oe_o  <= 1'b0;
                state_reg <= ST_WDATA;
              end
            end
          end
          ST_WDATA: begin
            if (scl_rise) begin
              shift_reg   <= shift_in(shift_reg, sda_reg);
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && byte_done(bit_cnt_reg)) begin
              // Counter cleared so no stale count survives into the wait state
              bit_cnt_reg <= 4'h0;
              sda_oe_o   <= 1'b1;
              rx_data_o  <= shift_reg;
              rx_valid_o <= 1'b1;
              state_reg  <= ST_WACK;
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              sda_oe_o  <= 1'b0;
              // RULE_10 single byte only
              state_reg <= ST_WAIT;
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (byte_done(bit_cnt_reg)) begin
                sda_oe_o  <= 1'b0;
                state_reg <= ST_RACK;
              end else begin
                sda_oe_o    <= pull_for(shift_reg[7]);
                shift_reg   <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK: begin
            // Master answer ignored: only one byte is ever sent
            if (scl_fall)
              state_reg <= ST_WAIT;
          end
          ST_WAIT: begin
            sda_oe_o <= 1'b0;
          end
          default: begin
            state_reg <= ST_IDLE;
            sda_oe_o  <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// ### dhis_host.sv
`timescale 1ns/1ns
module dhis_host (
  input  wire clk_i,
  input  wire sda_i,
  output reg  scl_o = 1'b1,
  output reg  sda_lo_o = 1'b0
);
  task q(input integer n); repeat (25 * n) @(posedge clk_i); endtask
  task byx(input logic [7:0] b, output logic [7:0] r, output logic k);
    for (int i = 8; i >= 0; i--) begin
      // Moving SDA only while SCL is low
      sda_lo_o <= i > 0 && !b[i - 1];
      q(1); scl_o <= 1'b1; q(1);
      if (i > 0) r[i - 1] = sda_i; else k = sda_i;
      q(1); scl_o <= 1'b0; q(1);
    end
  endtask
  task xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r,
            output logic a1, output logic a2);
    logic [7:0] t;
    sda_lo_o <= 1'b1; q(2); scl_o <= 1'b0; q(1);
    byx(a, t, a1);
    byx(a[0] ? 8'hFF : d, r, a2);
    sda_lo_o <= 1'b1; q(1); scl_o <= 1'b1; q(1); sda_lo_o <= 1'b0; q(2);
  endtask
endmodule

// ### dhis_i2c_slave_props.sv
`timescale 1ns/1ns
module dhis_i2c_slave_props (
  input wire clk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire i2c_mode_o,
  input wire rx_valid_o,
  input wire tx_taken_o,
  input wire busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start; scl_i && !sda_i; endsequence
  a_open_drain: assert property (sda_oe_o |-> !sda_o) else $error("sda");
  a_idle_quiet: assert property (!busy_o |-> !sda_oe_o) else $error("idle");
  a_mode_quiet: assert property (!i2c_mode_o |-> !busy_o) else $error("mode");
  a_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("scl");
  a_rx_once: assert property (rx_valid_o |=> !rx_valid_o [*8]) else $error("rx");
  a_tx_ack: assert property (tx_taken_o |-> $past(sda_oe_o, 2)) else $error("tx");
  a_busy_start: assert property ($rose(busy_o) |-> s_start) else $error("start");
  a_busy_stop: assert property ($fell(busy_o) |-> scl_i && sda_i) else $error("stop");
endmodule
bind dhis_i2c_slave dhis_i2c_slave_props u_props (.*);

// ### dhis_tb.sv
`timescale 1ns/1ns
module testbench;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         mode_select_strap_i = 1'b0, addr_strap_high_i = 1'b0, addr_strap_low_i = 1'b0;
  reg  [7:0]  tx_data_i = 8'h96;
  wire        scl_i, lo, sda_o, sda_oe_o, i2c_mode_o, rx_valid_o;
  wire [7:0]  rx_data_o;
  wire        tx_taken_o, busy_o;
  integer     n_rx = 0, n_tx = 0, n_busy = 0, b_rx, b_tx, b_bu;
  reg         busy_d = 1'b0;
  // Pulse counters, so one-cycle outputs are never missed
  always @(posedge clk_i) begin
    n_rx   <= n_rx + (rx_valid_o === 1'b1);
    n_tx   <= n_tx + (tx_taken_o === 1'b1);
    n_busy <= n_busy + (busy_o === 1'b1 && !busy_d);
    busy_d <= (busy_o === 1'b1);
  end
  // Pull-up wins unless a party pulls low
  wire        sda_i = !(lo || (sda_oe_o && !sda_o));
  integer     err_total = 0, n_compared = 0;
  logic [7:0] r;
  logic       a1, a2;
  always #50 clk_i = ~clk_i;
  dhis_host u_dhis_host (.clk_i, .sda_i, .scl_o(scl_i), .sda_lo_o(lo));
  dhis_i2c_slave u_dhis_i2c_slave (.*);
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task rst(input logic [2:0] v);
    @(posedge clk_i);
    rst_i <= 1'b1;
    {mode_select_strap_i, addr_strap_high_i, addr_strap_low_i} <= v;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task t_addr;
    for (int s = 0; s < 4; s++) begin
      rst(s[2:0]);
      b_rx = n_rx;
      b_bu = n_busy;
      u_dhis_host.xfer({5'h07, s[1:0], 1'b0}, 8'hC3 ^ s[7:0], r, a1, a2);
      chk("ack", 8'h00, {6'h00, a1, a2});
      chk("rx", 8'hC3 ^ s[7:0], rx_data_o);
      chk("rx_valid", 8'h01, n_rx[7:0] - b_rx[7:0]);
      chk("busy_rise", 8'h01, n_busy[7:0] - b_bu[7:0]);
      chk("busy_end", 8'h00, {7'h00, busy_o});
      chk("sda_o", 8'h00, {7'h00, sda_o});
      u_dhis_host.xfer({5'h07, ~s[1:0], 1'b0}, 8'h00, r, a1, a2);
      chk("nack", 8'h03, {6'h00, a1, a2});
      chk("rx_none", 8'h01, n_rx[7:0] - b_rx[7:0]);
    end
  endtask
  task t_read;
    b_tx = n_tx;
    u_dhis_host.xfer(8'h3F, 8'h00, r, a1, a2);
    chk("rd", 8'h96, r);
    chk("tx_taken", 8'h01, n_tx[7:0] - b_tx[7:0]);
    chk("rd_ack", 8'h00, {7'h00, a1});
  endtask
  task t_mode;
    rst(3'h4);
    mode_select_strap_i <= 1'b0;
    b_bu = n_busy;
    u_dhis_host.xfer(8'h38, 8'h55, r, a1, a2);
    chk("off", 8'h01, {7'h00, a1});
    chk("off_busy", 8'h00, n_busy[7:0] - b_bu[7:0]);
    rst(3'h0);
    chk("on", 8'h01, {7'h00, i2c_mode_o});
  endtask
  task summarize;
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    t_addr;
    t_read;
    t_mode;
    summarize;
  end
endmodule
